/* File: hdl/sysint_pkg.sv */
// package: shared constants and carrier types of the system integration unit
package sysint_pkg;

  // register byte addresses on the apb
  localparam logic [15:0] ADDR_BREAK_STATUS = 16'hfe00;
  localparam logic [15:0] ADDR_RESET_SOURCE = 16'hfe01;
  localparam logic [15:0] ADDR_BREAK_CLEAR  = 16'hfe03;

  // field positions
  localparam int BIT_BREAK_EXITED_WAIT = 1;
  localparam int BIT_BREAK_CLEAR_EN    = 7;
  localparam int BIT_POR               = 7;
  localparam int BIT_PIN               = 6;
  localparam int BIT_WATCHDOG          = 5;
  localparam int BIT_BAD_OPCODE        = 4;
  localparam int BIT_BAD_ADDRESS       = 3;
  localparam int BIT_MONITOR           = 1;
  localparam int BIT_LOW_VOLTAGE       = 0;

  // reset values
  localparam logic [7:0] RESET_SOURCE_POR = 8'h80;
  localparam logic [7:0] BYTE_ZERO        = 8'h00;
  localparam logic [7:0] BYTE_ERASED      = 8'hff;

  // timing counts in crystal clock cycles, and the swi vector address
  localparam logic [12:0] STOP_RECOVERY_LONG  = 13'h1000;
  localparam logic [12:0] STOP_RECOVERY_SHORT = 13'h0020;
  localparam logic [5:0]  PIN_SAMPLE_DELAY    = 6'h20;
  localparam logic [5:0]  RESET_DRIVE_CYCLES  = 6'h20;
  localparam logic [15:0] SWI_VECTOR          = 16'hfffc;

  typedef enum logic [2:0] {
    ST_RUN     = 3'b000,
    ST_WAIT    = 3'b001,
    ST_STOP    = 3'b010,
    ST_RECOVER = 3'b011,
    ST_STACK   = 3'b100
  } power_state_t;

  typedef enum logic [1:0] {
    RS_IDLE   = 2'b00,
    RS_DRIVE  = 2'b01,
    RS_SAMPLE = 2'b10
  } reset_state_t;

  typedef struct packed {
    logic       watchdog;
    logic       bad_opcode;
    logic       bad_address;
    logic       low_voltage;
    logic       monitor;
  } reset_cause_t;

endpackage : sysint_pkg

/* File: hdl/flag_guard.sv */
// flag_guard: decides whether peripheral flag clears may take effect
`timescale 1ns/100ps
module flag_guard (
  input  wire logic REF_CLK,        // bus clock
  input  wire logic RST_B,          // synchronous reset, active low
  input  wire logic in_break,       // cpu is in break state
  input  wire logic clear_enable,   // break clear enable bit
  input  wire logic first_step,     // first access of a two-step clear
  input  wire logic clear_request,  // a normal clearing access or second step
  output      logic clear_allow     // clear may take effect this cycle
);

  typedef struct packed {
    logic armed;
  } guard_state_t;

  guard_state_t state_reg;
  guard_state_t state_next;

  // a first step armed before break stays armed; a clear during protected break
  // is simply dropped, so the flag stays set and the second step after break clears it
  always_comb begin
    state_next = state_reg;
    if (first_step) begin
      state_next.armed = 1'b1;
    end
    if (clear_allow) begin
      state_next.armed = 1'b0;
    end
  end

  always_comb begin
    clear_allow = clear_request & (~in_break | clear_enable);
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : flag_guard

/* File: hdl/sysint_unit.sv */
// system_integration_unit: break entry, low-power sequencing and reset status
//
// Summary of operation
// - break request forces cpu to swi vector
// - break protects flags unless clear enable set
// - flag cleared during break stays cleared
// - two-step clears protected across break entry
// - wait or stop clears interrupt mask
// - wait gates cpu clocks, peripherals run
// - wait wakeup stacks one cycle later
// - reset or break exits wait, break sets flag in emulation only
// - watchdog runs in wait unless disabled
// - stop resets counter, disables both clocks
// - stop exits by interrupt after recovery
// - recovery 4096 cycles, or 32 if short
// - counter held in stop, times recovery
// - decode three registers at fixed addresses
// - break status works in emulation only
// - reading reset status clears all flags
// - internal reset drives pin, samples later
// - separate flag for each reset source
// - monitor flag on erased vector, irq high
`timescale 1ns/100ps
module sysint_unit (
  input  wire logic        REF_CLK,          // crystal and bus clock, 40 mhz
  input  wire logic        RST_B,            // synchronous reset, active low
  input  wire logic        POWER_ON,         // power-on reset event, one cycle
  input  wire logic        PSEL,             // apb select
  input  wire logic        PENABLE,          // apb enable
  input  wire logic        PWRITE,           // apb direction
  input  wire logic [15:0] PADDR,            // apb byte address
  input  wire logic [31:0] PWDATA,           // apb write data
  output      logic [31:0] PRDATA,           // apb read data
  output      logic        PREADY,           // apb ready
  output      logic        PSLVERR,          // apb error on unmapped address
  input  wire logic        BREAK_REQ,        // break module request
  input  wire logic        WAIT_EXEC,        // cpu executes wait, one cycle
  input  wire logic        STOP_EXEC,        // cpu executes stop, one cycle
  input  wire logic        IRQ_PENDING,      // enabled module interrupt request
  input  wire logic        EMULATION,        // emulation mode strap
  input  wire logic        WATCHDOG_DISABLE, // watchdog disable option bit
  input  wire logic        SHORT_STOP,       // short stop recovery option bit
  input  wire logic        CAUSE_WATCHDOG,   // watchdog timeout reset event
  input  wire logic        CAUSE_BAD_OP,     // illegal opcode reset event
  input  wire logic        CAUSE_BAD_ADDR,   // illegal address fetch reset event
  input  wire logic        CAUSE_LOW_VOLT,   // low voltage reset event
  input  wire logic        CAUSE_MONITOR,    // monitor entry reset request
  input  wire logic [7:0]  VECTOR_HI,        // reset vector high byte
  input  wire logic [7:0]  VECTOR_LO,        // reset vector low byte
  input  wire logic        IRQ_PIN,          // interrupt pin level
  input  wire logic        RST_PIN_IN,       // reset pin level
  input  wire logic        FLAG_FIRST_STEP,  // peripheral first clear step
  input  wire logic        FLAG_CLEAR_REQ,   // peripheral clearing access
  output      logic        FLAG_CLEAR_OK,    // clear may take effect
  output      logic        RST_PIN_OUT,      // reset pin drive value
  output      logic        RST_PIN_OE,       // reset pin output enable
  output      logic        CPU_CLK_EN,       // cpu clock gate
  output      logic        PERIPH_CLK_EN,    // peripheral and crystal clock gate
  output      logic        WATCHDOG_RUN,     // watchdog enabled
  output      logic        FORCE_SWI,        // force fetch from swi vector, pulse
  output      logic [15:0] VECTOR_ADDR,      // vector to fetch
  output      logic        CLEAR_IMASK,      // clear cpu interrupt mask, pulse
  output      logic        START_STACK,      // begin interrupt stacking, pulse
  output      logic        IN_BREAK          // cpu in break state
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    sysint_pkg::power_state_t pwr;
    sysint_pkg::reset_state_t rst;
    logic [12:0] count;
    logic [5:0]  rst_count;
    logic        brk;
    logic        exited_wait;
    logic        clear_en;
    logic [7:0]  reset_src;
    logic        pin_s1;
    logic        pin_s2;
    logic        irq_s1;
    logic        irq_s2;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rst_oe;
    logic        cpu_clk;
    logic        per_clk;
    logic        wdog;
    logic        software_interrupt;
    logic        clr_mask;
    logic        stack;
    logic        clear_ok;
  } unit_state_t;

  unit_state_t s_reg;
  unit_state_t s_next;
  logic        clear_allow;

  function automatic logic [7:0] read_mux(input logic [15:0] addr, input unit_state_t s);
    logic [7:0] v;
    v = sysint_pkg::BYTE_ZERO;
    case (addr)
      sysint_pkg::ADDR_BREAK_STATUS: v[sysint_pkg::BIT_BREAK_EXITED_WAIT] = s.exited_wait;
      sysint_pkg::ADDR_RESET_SOURCE: v = s.reset_src;
      sysint_pkg::ADDR_BREAK_CLEAR:  v[sysint_pkg::BIT_BREAK_CLEAR_EN] = s.clear_en;
      default:                       v = sysint_pkg::BYTE_ZERO;
    endcase
    return v;
  endfunction : read_mux

  function automatic logic mapped(input logic [15:0] addr);
    return (addr == sysint_pkg::ADDR_BREAK_STATUS) ||
           (addr == sysint_pkg::ADDR_RESET_SOURCE) ||
           (addr == sysint_pkg::ADDR_BREAK_CLEAR);
  endfunction : mapped

  flag_guard u_guard (
    .REF_CLK       (REF_CLK),
    .RST_B         (RST_B),
    .in_break      (s_reg.brk),
    .clear_enable  (s_reg.clear_en),
    .first_step    (FLAG_FIRST_STEP),
    .clear_request (FLAG_CLEAR_REQ),
    .clear_allow   (clear_allow)
  );

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic setup;
    logic access;
    logic vec_erased;
    setup      = PSEL & ~PENABLE;
    access     = PSEL & PENABLE & s_reg.pready;
    vec_erased = (VECTOR_HI == sysint_pkg::BYTE_ERASED) && (VECTOR_LO == sysint_pkg::BYTE_ERASED);
    s_next = s_reg;
    s_next.pin_s1   = RST_PIN_IN;
    s_next.pin_s2   = s_reg.pin_s1;
    s_next.irq_s1   = IRQ_PIN;
    s_next.irq_s2   = s_reg.irq_s1;
    s_next.software_interrupt      = 1'b0;
    s_next.clr_mask = 1'b0;
    s_next.stack    = 1'b0;
    s_next.clear_ok = clear_allow;

    // apb: no wait state, answer in the cycle after setup
    s_next.pready  = setup;
    s_next.pslverr = setup & ~mapped(PADDR);
    if (setup && !PWRITE) begin
      s_next.prdata = {24'h00_0000, read_mux(PADDR, s_reg)};
    end
    if (access && PWRITE && PADDR == sysint_pkg::ADDR_BREAK_CLEAR) begin
      s_next.clear_en = PWDATA[sysint_pkg::BIT_BREAK_CLEAR_EN];
    end
    if (access && !PWRITE && PADDR == sysint_pkg::ADDR_RESET_SOURCE) begin
      s_next.reset_src = sysint_pkg::BYTE_ZERO;
    end
    if (access && PWRITE && PADDR == sysint_pkg::ADDR_BREAK_STATUS && EMULATION) begin
      s_next.exited_wait = PWDATA[sysint_pkg::BIT_BREAK_EXITED_WAIT];
    end

    // break entry
    if (BREAK_REQ && !s_reg.brk) begin
      s_next.brk = 1'b1;
      s_next.software_interrupt = 1'b1;
    end else if (!BREAK_REQ) begin
      s_next.brk = 1'b0;
    end

    // watchdog stays on in every state but stop unless disabled
    s_next.wdog = ~WATCHDOG_DISABLE & (s_reg.pwr != sysint_pkg::ST_STOP);

    case (s_reg.pwr)
      sysint_pkg::ST_RUN: begin
        s_next.cpu_clk = 1'b1;
        s_next.per_clk = 1'b1;
        if (WAIT_EXEC) begin
          s_next.pwr      = sysint_pkg::ST_WAIT;
          s_next.clr_mask = 1'b1;
          s_next.cpu_clk  = 1'b0;
        end else if (STOP_EXEC) begin
          s_next.pwr      = sysint_pkg::ST_STOP;
          s_next.clr_mask = 1'b1;
          s_next.cpu_clk  = 1'b0;
          s_next.per_clk  = 1'b0;
          s_next.count    = 13'h0000;
        end
      end
      sysint_pkg::ST_WAIT: begin
        if (BREAK_REQ) begin
          s_next.pwr         = sysint_pkg::ST_RUN;
          s_next.cpu_clk     = 1'b1;
          s_next.exited_wait = EMULATION;
        end else if (IRQ_PENDING) begin
          s_next.pwr     = sysint_pkg::ST_RUN;
          s_next.cpu_clk = 1'b1;
          s_next.stack   = 1'b1;
        end
      end
      sysint_pkg::ST_STOP: begin
        s_next.count = 13'h0000;
        if (IRQ_PENDING) begin
          s_next.pwr     = sysint_pkg::ST_RECOVER;
          s_next.per_clk = 1'b1;
        end
      end
      sysint_pkg::ST_RECOVER: begin
        s_next.count = s_reg.count + 13'h0001;
        if (s_reg.count == (SHORT_STOP ? sysint_pkg::STOP_RECOVERY_SHORT
                                       : sysint_pkg::STOP_RECOVERY_LONG) - 13'h0001) begin
          s_next.pwr = sysint_pkg::ST_STACK;
        end
      end
      sysint_pkg::ST_STACK: begin
        s_next.pwr     = sysint_pkg::ST_RUN;
        s_next.cpu_clk = 1'b1;
        s_next.stack   = 1'b1;
      end
      default: s_next.pwr = sysint_pkg::ST_RUN;
    endcase

    // reset sources; internal reset events drive the pin, then sample it
    if (CAUSE_WATCHDOG | CAUSE_BAD_OP | CAUSE_BAD_ADDR | CAUSE_LOW_VOLT | CAUSE_MONITOR) begin
      s_next.reset_src = sysint_pkg::BYTE_ZERO;
      s_next.reset_src[sysint_pkg::BIT_WATCHDOG]    = CAUSE_WATCHDOG;
      s_next.reset_src[sysint_pkg::BIT_BAD_OPCODE]  = CAUSE_BAD_OP;
      s_next.reset_src[sysint_pkg::BIT_BAD_ADDRESS] = CAUSE_BAD_ADDR;
      s_next.reset_src[sysint_pkg::BIT_LOW_VOLTAGE] = CAUSE_LOW_VOLT;
      s_next.reset_src[sysint_pkg::BIT_MONITOR]     = CAUSE_MONITOR & vec_erased
                                                      & s_reg.irq_s2;
      s_next.rst       = sysint_pkg::RS_DRIVE;
      s_next.rst_oe    = 1'b1;
      s_next.rst_count = 6'h00;
      s_next.pwr       = sysint_pkg::ST_RUN;
    end else if (s_reg.rst == sysint_pkg::RS_IDLE && !s_reg.pin_s2) begin
      s_next.reset_src = sysint_pkg::BYTE_ZERO;
      s_next.reset_src[sysint_pkg::BIT_PIN] = 1'b1;
      s_next.pwr       = sysint_pkg::ST_RUN;
    end else begin
      case (s_reg.rst)
        sysint_pkg::RS_IDLE: s_next.rst_oe = 1'b0;
        sysint_pkg::RS_DRIVE: begin
          s_next.rst_count = s_reg.rst_count + 6'h01;
          if (s_reg.rst_count == sysint_pkg::RESET_DRIVE_CYCLES - 6'h01) begin
            s_next.rst       = sysint_pkg::RS_SAMPLE;
            s_next.rst_oe    = 1'b0;
            s_next.rst_count = 6'h00;
          end
        end
        sysint_pkg::RS_SAMPLE: begin
          s_next.rst_count = s_reg.rst_count + 6'h01;
          if (s_reg.rst_count == sysint_pkg::PIN_SAMPLE_DELAY - 6'h01) begin
            s_next.rst = sysint_pkg::RS_IDLE;
            if (!s_reg.pin_s2) begin
              s_next.reset_src[sysint_pkg::BIT_PIN] = 1'b1;
            end
          end
        end
        default: s_next.rst = sysint_pkg::RS_IDLE;
      endcase
    end

    if (POWER_ON) begin
      s_next.reset_src = sysint_pkg::RESET_SOURCE_POR;
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      s_reg           <= '0;
      s_reg.pwr       <= sysint_pkg::ST_RUN;
      s_reg.rst       <= sysint_pkg::RS_IDLE;
      s_reg.reset_src <= sysint_pkg::RESET_SOURCE_POR;
      s_reg.pin_s1    <= 1'b1;
      s_reg.pin_s2    <= 1'b1;
      s_reg.cpu_clk   <= 1'b1;
      s_reg.per_clk   <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  always_comb begin
    PRDATA        = s_reg.prdata;
    PREADY        = s_reg.pready;
    PSLVERR       = s_reg.pslverr;
    FLAG_CLEAR_OK = s_reg.clear_ok;
    RST_PIN_OUT   = 1'b0;
    RST_PIN_OE    = s_reg.rst_oe;
    CPU_CLK_EN    = s_reg.cpu_clk;
    PERIPH_CLK_EN = s_reg.per_clk;
    WATCHDOG_RUN  = s_reg.wdog;
    FORCE_SWI     = s_reg.software_interrupt;
    VECTOR_ADDR   = sysint_pkg::SWI_VECTOR;
    CLEAR_IMASK   = s_reg.clr_mask;
    START_STACK   = s_reg.stack;
    IN_BREAK      = s_reg.brk;
  end

endmodule : sysint_unit

/* File: verification/sysint_checker.sv */
// checker: timing properties watched on the system integration unit ports
`timescale 1ns/100ps
module sysint_checker (
  input wire logic        REF_CLK,        // clock
  input wire logic        RST_B,          // reset, active low
  input wire logic        PSEL,           // apb select
  input wire logic        PENABLE,        // apb enable
  input wire logic        PWRITE,         // apb direction
  input wire logic [15:0] PADDR,          // apb address
  input wire logic [31:0] PWDATA,         // apb write data
  input wire logic        PREADY,         // apb ready
  input wire logic        BREAK_REQ,      // break request
  input wire logic        WAIT_EXEC,      // wait executed
  input wire logic        STOP_EXEC,      // stop executed
  input wire logic        IRQ_PENDING,    // interrupt request
  input wire logic        SHORT_STOP,     // short recovery
  input wire logic        FLAG_CLEAR_REQ, // clearing access
  input wire logic        FLAG_CLEAR_OK,  // clear allowed
  input wire logic        RST_PIN_OE,     // pin drive
  input wire logic        CPU_CLK_EN,     // cpu clock gate
  input wire logic        PERIPH_CLK_EN,  // peripheral clock gate
  input wire logic        FORCE_SWI,      // swi forcing
  input wire logic        CLEAR_IMASK,    // mask clear
  input wire logic        START_STACK,    // stacking start
  input wire logic        IN_BREAK        // break state
);
  // ----------------------------------------------------------------
  // shadow state
  // ----------------------------------------------------------------
  logic        break_clear_enable_q;
  logic        waiting;
  logic        stopped;
  logic [5:0]  oe_cnt;
  logic [13:0] rec_cnt;
  wire  [13:0] lim = SHORT_STOP ? {1'b0, sysint_pkg::STOP_RECOVERY_SHORT}
                                : {1'b0, sysint_pkg::STOP_RECOVERY_LONG};
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      break_clear_enable_q  <= 1'b0;
      waiting <= 1'b0;
      stopped <= 1'b0;
      oe_cnt  <= 6'h00;
      rec_cnt <= 14'h0000;
    end else begin
      if (PSEL && PENABLE && PREADY && PWRITE && PADDR == sysint_pkg::ADDR_BREAK_CLEAR) begin
        break_clear_enable_q <= PWDATA[sysint_pkg::BIT_BREAK_CLEAR_EN];
      end
      waiting <= WAIT_EXEC || (waiting && !CPU_CLK_EN && !STOP_EXEC);
      stopped <= STOP_EXEC || (stopped && !START_STACK);
      oe_cnt  <= RST_PIN_OE ? oe_cnt + 6'h01 : 6'h00;
      // only cycles with the crystal clock back on count toward recovery
      rec_cnt <= !stopped ? 14'h0000 : rec_cnt + {13'h0000, PERIPH_CLK_EN && !CPU_CLK_EN};
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  sequence s_wait_in;
    CLEAR_IMASK && !CPU_CLK_EN && PERIPH_CLK_EN;
  endsequence
  sequence s_stop_in;
    CLEAR_IMASK && !CPU_CLK_EN && !PERIPH_CLK_EN;
  endsequence
  sequence s_wake;
    START_STACK && CPU_CLK_EN;
  endsequence
  a_break_forces_swi: assert property ($rose(BREAK_REQ) |=> FORCE_SWI && IN_BREAK)
    else $error("break did not force swi");
  a_clear_passes: assert property (FLAG_CLEAR_REQ && (!IN_BREAK || break_clear_enable_q) |=> FLAG_CLEAR_OK)
    else $error("clear not allowed");
  a_clear_blocked: assert property (FLAG_CLEAR_REQ && IN_BREAK && !break_clear_enable_q |=> !FLAG_CLEAR_OK)
    else $error("clear not blocked in break");
  a_wait_entry: assert property (WAIT_EXEC |=> s_wait_in)
    else $error("wait entry wrong");
  a_stop_entry: assert property (STOP_EXEC |=> s_stop_in)
    else $error("stop entry wrong");
  a_wait_wake: assert property (waiting && !CPU_CLK_EN && IRQ_PENDING |=> s_wake)
    else $error("wait wakeup late");
  a_break_wake: assert property (waiting && !CPU_CLK_EN && $rose(BREAK_REQ) |-> ##[1:2] CPU_CLK_EN)
    else $error("break did not end wait");
  a_stop_recovery: assert property (START_STACK && stopped |-> rec_cnt >= lim && rec_cnt <= lim + 14'h0004)
    else $error("stop recovery length wrong");
  a_pin_drive_len: assert property ($fell(RST_PIN_OE) |-> oe_cnt == sysint_pkg::RESET_DRIVE_CYCLES)
    else $error("reset pin drive length wrong");
  a_apb_answer: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("apb answer late");
endmodule : sysint_checker

bind sysint_unit sysint_checker sysint_checker_inst (.*);

/* File: verification/sysint_partner.sv */
// far side model: reset pin with pull-up and one peripheral status flag
`timescale 1ns/100ps
module sysint_partner (
  input  wire logic clk,      // bus clock
  input  wire logic rst_b,    // reset, active low
  input  wire logic pin_oe,   // device drives the pin
  input  wire logic pin_out,  // device drive level
  input  wire logic ext_low,  // outside switch pulls low
  input  wire logic set_flag, // peripheral event
  input  wire logic clear_ok, // clear allowed by device
  output      logic pin_in,   // resolved pin level
  output      logic flag      // peripheral flag
);
  // the pull-up wins only when no party pulls the pin down
  assign pin_in = ((pin_oe && !pin_out) || ext_low) ? 1'b0 : 1'b1;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flag <= 1'b0;
    end else if (set_flag) begin
      flag <= 1'b1;
    end else if (clear_ok) begin
      flag <= 1'b0;
    end
  end
endmodule : sysint_partner

/* File: verification/sysint_unit_test.sv */
// testbench of the system integration unit
`timescale 1ns/100ps
module sysint_unit_test;
  // ----------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------
  logic REF_CLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic BREAK_REQ = 1'b0, IRQ_PENDING = 1'b0, EMULATION = 1'b0, SHORT_STOP = 1'b0;
  logic WATCHDOG_DISABLE = 1'b0, IRQ_PIN = 1'b1, ext_low = 1'b0, set_flag = 1'b0;
  logic [15:0] PADDR = 16'h0000;
  logic [31:0] PWDATA = 32'h0000_0000, rng = 32'h0000_4fa2, rd, r;
  logic [7:0]  VECTOR_HI = 8'hff, VECTOR_LO = 8'hff;
  logic [9:0]  pv = 10'h000;
  logic [31:0] PRDATA;
  logic [15:0] VECTOR_ADDR;
  logic PREADY, PSLVERR, FLAG_CLEAR_OK, RST_PIN_OUT, RST_PIN_OE, CPU_CLK_EN, PERIPH_CLK_EN;
  logic WATCHDOG_RUN, FORCE_SWI, CLEAR_IMASK, START_STACK, IN_BREAK, err, pflag;
  wire  WAIT_EXEC, STOP_EXEC, FLAG_CLEAR_REQ, FLAG_FIRST_STEP, CAUSE_WATCHDOG, CAUSE_BAD_OP;
  wire  CAUSE_BAD_ADDR, CAUSE_LOW_VOLT, CAUSE_MONITOR, POWER_ON, RST_PIN_IN;
  int   num_errors = 0, checked = 0, n, lim;
  assign {POWER_ON, CAUSE_MONITOR, CAUSE_LOW_VOLT, CAUSE_BAD_ADDR, CAUSE_BAD_OP,
          CAUSE_WATCHDOG, FLAG_FIRST_STEP, FLAG_CLEAR_REQ, STOP_EXEC, WAIT_EXEC} = pv;
  always #12.5 REF_CLK = ~REF_CLK;
  sysint_unit sysint_unit_inst (.*);
  sysint_partner sysint_partner_inst (.clk(REF_CLK), .rst_b(RST_B), .pin_oe(RST_PIN_OE),
    .pin_out(RST_PIN_OUT), .ext_low(ext_low), .set_flag(set_flag),
    .clear_ok(FLAG_CLEAR_OK), .pin_in(RST_PIN_IN), .flag(pflag));
  function logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs
  function automatic logic [31:0] want_src(int k);
    case (k)
      4: return 32'h0000_0001 << sysint_pkg::BIT_WATCHDOG;
      5: return 32'h0000_0001 << sysint_pkg::BIT_BAD_OPCODE;
      6: return 32'h0000_0001 << sysint_pkg::BIT_BAD_ADDRESS;
      7: return 32'h0000_0001 << sysint_pkg::BIT_LOW_VOLTAGE;
      8: return 32'h0000_0001 << sysint_pkg::BIT_MONITOR;
      9: return 32'h0000_0001 << sysint_pkg::BIT_PIN;
      default: return want_src(4) | want_src(9);
    endcase
  endfunction : want_src
  task check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      num_errors++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task close_out();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task tick(input int c);
    repeat (c) @(posedge REF_CLK);
  endtask : tick
  task pls(input int k);
    @(posedge REF_CLK);
    pv <= 10'h001 << k;
    @(posedge REF_CLK);
    pv <= 10'h000;
    #1;
  endtask : pls
  // holds every request signal until pready is seen high at an edge
  task apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    @(posedge REF_CLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, wr, a, wd};
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge REF_CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
  endtask : apb
  task rdc(input logic [15:0] a, input logic [31:0] m, input logic [31:0] w);
    apb(1'b0, a, 32'h0000_0000);
    check(rd & m, w);
  endtask : rdc
  task brk(input logic v);
    @(posedge REF_CLK);
    BREAK_REQ <= v;
    tick(3);
  endtask : brk
  initial begin
    tick(20000);
    num_errors++;
    close_out();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(5);
    RST_B <= 1'b1;
    rdc(sysint_pkg::ADDR_RESET_SOURCE, 32'hff, 32'h80);
    rdc(sysint_pkg::ADDR_RESET_SOURCE, 32'hff, 32'h00);
    apb(1'b0, 16'hfe02, 32'h0000_0000);
    check(err, 1'b1);
    check(rd, 32'h0000_0000);
    repeat (16) begin
      r = xs();
      apb(1'b1, sysint_pkg::ADDR_BREAK_CLEAR, r);
      rdc(sysint_pkg::ADDR_BREAK_CLEAR, 32'h80, r & 32'h80);
      brk(r[8]);
      pls(2);
      check(FLAG_CLEAR_OK, !r[8] || r[7]);
      brk(1'b0);
    end
    for (int b = 0; b < 2; b++) begin
      @(posedge REF_CLK);
      set_flag <= 1'b1;
      @(posedge REF_CLK);
      set_flag <= 1'b0;
      apb(1'b1, sysint_pkg::ADDR_BREAK_CLEAR, {24'h00_0000, b[0], 7'h00});
      pls(3);
      @(posedge REF_CLK);
      BREAK_REQ <= 1'b1;
      @(posedge REF_CLK);
      #1;
      check({FORCE_SWI, IN_BREAK, VECTOR_ADDR}, {2'b11, 16'hfffc});
      pls(2);
      tick(2);
      check(pflag, !b[0]);
      brk(1'b0);
      pls(2);
      tick(2);
      check(pflag, 1'b0);
    end
    for (int e = 0; e < 3; e++) begin
      @(posedge REF_CLK);
      EMULATION <= (e == 1);
      WATCHDOG_DISABLE <= (e == 2);
      pls(0);
      check({CLEAR_IMASK, CPU_CLK_EN, PERIPH_CLK_EN}, 3'b101);
      check(WATCHDOG_RUN, e != 2);
      @(posedge REF_CLK);
      {IRQ_PENDING, BREAK_REQ} <= (e == 0) ? 2'b10 : 2'b01;
      @(posedge REF_CLK);
      #1;
      if (e == 0) check(START_STACK, 1'b1);
      tick(2);
      check(CPU_CLK_EN, 1'b1);
      rdc(sysint_pkg::ADDR_BREAK_STATUS, 32'h02, (e == 1) ? 32'h02 : 32'h00);
      @(posedge REF_CLK);
      {IRQ_PENDING, BREAK_REQ} <= 2'b00;
      tick(3);
    end
    for (int s = 0; s < 2; s++) begin
      @(posedge REF_CLK);
      SHORT_STOP <= (s == 0);
      pls(1);
      check({CLEAR_IMASK, CPU_CLK_EN, PERIPH_CLK_EN}, 3'b100);
      tick(5);
      IRQ_PENDING <= 1'b1;
      n = 0;
      do begin
        @(posedge REF_CLK);
        #1;
        n++;
      end while (START_STACK !== 1'b1 && n < 5000);
      lim = (s == 0) ? 32 : 4096;
      check(n >= lim && n <= lim + 4, 1'b1);
      @(posedge REF_CLK);
      IRQ_PENDING <= 1'b0;
    end
    for (int k = 4; k < 11; k++) begin
      @(posedge REF_CLK);
      ext_low <= (k >= 9);
      if (k != 9) begin
        pls((k == 10) ? 4 : k);
        n = 0;
        while (RST_PIN_OE !== 1'b1 && n < 100) begin
          @(posedge REF_CLK);
          n++;
        end
        check({RST_PIN_OE, RST_PIN_OUT}, 2'b10);
      end
      // with a cause the switch lets go right after the pin sample, else a
      // pin still low in idle would count as a fresh external reset
      tick((k == 10) ? 62 : 70);
      ext_low <= 1'b0;
      tick(20);
      rdc(sysint_pkg::ADDR_RESET_SOURCE, 32'hff, want_src(k));
    end
    pls(9);
    tick(80);
    rdc(sysint_pkg::ADDR_RESET_SOURCE, 32'hff, 32'h80);
    close_out();
  end
endmodule : sysint_unit_test
